// ### logic/prbst_engine.sv
// pattern test engine: connection memory, pattern transmitter, receiver and error tally
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module prbst_engine #(
	parameter int unsigned N_ST = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [prbst_pkg::ADDR_W-1:0] i_addr,
	input wire logic [prbst_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [prbst_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_link_clk,
	input wire logic i_frame_n,
	input wire logic [N_ST-1:0] i_serial_input_stream,
	output logic [N_ST-1:0] o_serial_output_stream,
	output logic [N_ST-1:0] o_serial_output_stream_oe,
	output logic o_irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [prbst_pkg::CM_W-1:0] cm_r [prbst_pkg::CM_DEPTH];
	logic [1:0] main_control_register_r;
	logic [15:0] rx_compare_start_register_r;
	logic [prbst_pkg::LEN_W-1:0] test_channel_length_register_r;
	logic [15:0] error_tally_register_r;
	logic [prbst_pkg::IRQ_W-1:0] irq_stat_r;
	logic [prbst_pkg::IRQ_W-1:0] irq_en_r;
	logic [prbst_pkg::IRQ_W-1:0] irq_clr;
	logic [prbst_pkg::IRQ_W-1:0] irq_evt;
	logic [prbst_pkg::DATA_W-1:0] rdata_nxt;
	logic pattern_test_run_bit;
	logic error_count_clear_bit;
	logic [N_ST+1:0] link_sync;
	logic link_clk_s;
	logic frame_s_n;
	logic [N_ST-1:0] sti_s;
	logic link_clk_d_r;
	logic link_rise;
	logic link_fall;
	logic [7:0] slot_r;
	logic [7:0] slot_nxt;
	logic [N_ST-1:0] sto_nxt;
	logic [N_ST-1:0] oe_nxt;
	logic [N_ST-1:0] is_test_v;
	logic [N_ST-1:0] tx_pick;
	logic any_test;
	logic tx_bit;
	prbst_pkg::prbst_rx_state_e rx_state_r;
	logic [8:0] rem_r;
	logic [prbst_pkg::CH_W-1:0] start_ch;
	logic [prbst_pkg::ST_W-1:0] start_st;
	logic [prbst_pkg::LEN_W-1:0] len_eff;
	logic start_hit;
	logic cmp_now;
	logic rx_bit;
	logic ref_bit;
	logic bit_err;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic is_cm(input logic [prbst_pkg::ADDR_W-1:0] a);
		is_cm = (a[11:9] == prbst_pkg::CM_REGION);
	endfunction : is_cm

	function automatic logic is_test(input logic [prbst_pkg::CM_W-1:0] e);
		is_test = (e[2:0] == prbst_pkg::CM_MODE_TEST);
	endfunction : is_test

	assign pattern_test_run_bit = main_control_register_r[prbst_pkg::CTRL_RUN_BIT];
	assign error_count_clear_bit = main_control_register_r[prbst_pkg::CTRL_CLR_BIT];
	assign start_ch = rx_compare_start_register_r[prbst_pkg::RXS_CH_LSB +: prbst_pkg::CH_W];
	assign start_st = rx_compare_start_register_r[prbst_pkg::RXS_ST_LSB +: prbst_pkg::ST_W];
	assign len_eff = (test_channel_length_register_r > prbst_pkg::LEN_MAX) ? prbst_pkg::LEN_MAX
		: test_channel_length_register_r;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	// connection memory, one entry per output stream and channel
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < prbst_pkg::CM_DEPTH; i++) begin
				cm_r[i] <= prbst_pkg::CM_RST;
			end
		end else if (i_wr && is_cm(i_addr)) begin
			cm_r[i_addr[8:0]] <= i_wdata[prbst_pkg::CM_W-1:0];
		end
	end

	// control, start and length registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			main_control_register_r <= prbst_pkg::CTRL_RST;
			rx_compare_start_register_r <= prbst_pkg::RXS_RST;
			test_channel_length_register_r <= prbst_pkg::LEN_RST;
			irq_en_r <= '0;
		end else if (i_wr) begin
			case (i_addr)
				prbst_pkg::ADDR_CTRL: main_control_register_r <= i_wdata[1:0];
				prbst_pkg::ADDR_RX_START: rx_compare_start_register_r <= i_wdata & prbst_pkg::RXS_MASK;
				prbst_pkg::ADDR_LENGTH: test_channel_length_register_r <= i_wdata[prbst_pkg::LEN_W-1:0];
				prbst_pkg::ADDR_IRQ_EN: irq_en_r <= i_wdata[prbst_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// read mux, answered one cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		if (is_cm(i_addr)) begin
			rdata_nxt = {4'h0, cm_r[i_addr[8:0]]};
		end else begin
			case (i_addr)
				prbst_pkg::ADDR_CTRL: rdata_nxt = {14'h0000, main_control_register_r};
				prbst_pkg::ADDR_RX_START: rdata_nxt = rx_compare_start_register_r;
				prbst_pkg::ADDR_LENGTH: rdata_nxt = {10'h000, test_channel_length_register_r};
				prbst_pkg::ADDR_ERR_TALLY: rdata_nxt = error_tally_register_r;
				prbst_pkg::ADDR_IRQ_STAT: rdata_nxt = {13'h0000, irq_stat_r};
				prbst_pkg::ADDR_IRQ_EN: rdata_nxt = {13'h0000, irq_en_r};
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// link timing
	// ------------------------------------------------------------
	prbst_sync #(
		.W(N_ST + 2)
	) u_link_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_link_clk, i_frame_n, i_serial_input_stream}),
		.o_sync(link_sync)
	);

	assign link_clk_s = link_sync[N_ST+1];
	assign frame_s_n = link_sync[N_ST];
	assign sti_s = link_sync[N_ST-1:0];
	assign link_rise = link_clk_s & ~link_clk_d_r;
	assign link_fall = ~link_clk_s & link_clk_d_r;
	// low frame pulse at a rising edge starts channel 0 bit 0
	assign slot_nxt = frame_s_n ? 8'(slot_r + 8'h01) : 8'h00;

	// edge finder and bit slot counter {channel, bit}
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_clk_d_r <= 1'b1;
			slot_r <= 8'h00;
		end else begin
			link_clk_d_r <= link_clk_s;
			if (link_rise) begin
				slot_r <= slot_nxt;
			end
		end
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	// per stream entry for the coming bit slot
	generate
		for (genvar s = 0; s < N_ST; s++) begin : g_st
			logic [prbst_pkg::CM_W-1:0] entry;
			assign entry = cm_r[{prbst_pkg::ST_W'(s), slot_nxt[7:3]}];
			assign is_test_v[s] = is_test(entry);
			always_comb begin
				sto_nxt[s] = 1'b1;
				oe_nxt[s] = 1'b1;
				if (!entry[0]) begin
					sto_nxt[s] = 1'b1; // switched channel, no data path here
				end else begin
					case (entry[2:0])
						prbst_pkg::CM_MODE_HIZ: oe_nxt[s] = 1'b0;
						prbst_pkg::CM_MODE_MSG: sto_nxt[s] = entry[prbst_pkg::CM_MSG_MSB - {1'b0, slot_nxt[2:0]}];
						prbst_pkg::CM_MODE_TEST: sto_nxt[s] = tx_pick[s] ? tx_bit : 1'b1;
						default: oe_nxt[s] = 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// only the lowest stream in test mode receives the pattern
	always_comb begin
		tx_pick = '0;
		for (int i = N_ST - 1; i >= 0; i--) begin
			if (is_test_v[i]) begin
				tx_pick = '0;
				tx_pick[i] = 1'b1;
			end
		end
	end

	assign any_test = |is_test_v;

	// generator held at seed while stopped, steps once per sent test bit
	prbst_lfsr u_tx_gen (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_load(~pattern_test_run_bit),
		.i_adv(link_rise & pattern_test_run_bit & any_test),
		.i_ext_en(1'b0),
		.i_ext_bit(1'b0),
		.o_bit(tx_bit)
	);

	// output stream bits change on the link rising edge
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_serial_output_stream <= '1;
			o_serial_output_stream_oe <= '0;
		end else if (link_rise) begin
			for (int i = 0; i < N_ST; i++) begin
				o_serial_output_stream[i] <= pattern_test_run_bit ? sto_nxt[i] : (sto_nxt[i] | is_test_v[i]);
			end
			o_serial_output_stream_oe <= oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	assign start_hit = (slot_r[7:3] == start_ch) && (slot_r[2:0] == 3'h0) && (len_eff != '0);
	assign cmp_now = link_fall && (rx_state_r == prbst_pkg::RX_CMP || (rx_state_r == prbst_pkg::RX_WAIT && start_hit));
	assign rx_bit = sti_s[start_st];
	assign bit_err = cmp_now && (rx_bit != ref_bit);

	// compare window: length channels of eight bits each
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_state_r <= prbst_pkg::RX_IDLE;
			rem_r <= 9'h000;
		end else if (!pattern_test_run_bit) begin
			rx_state_r <= prbst_pkg::RX_IDLE;
			rem_r <= 9'h000;
		end else begin
			case (rx_state_r)
				prbst_pkg::RX_IDLE: rx_state_r <= prbst_pkg::RX_WAIT;
				prbst_pkg::RX_WAIT: begin
					if (cmp_now) begin
						rem_r <= 9'({len_eff, 3'h0} - 9'h001);
						rx_state_r <= prbst_pkg::RX_CMP;
					end
				end
				prbst_pkg::RX_CMP: begin
					if (cmp_now) begin
						if (rem_r == 9'h001) begin
							rx_state_r <= prbst_pkg::RX_WAIT;
						end
						rem_r <= 9'(rem_r - 9'h001);
					end
				end
				default: rx_state_r <= prbst_pkg::RX_IDLE;
			endcase
		end
	end

	// reference fed by the received bits, so it locks after one register length
	prbst_lfsr u_rx_ref (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_load(~pattern_test_run_bit),
		.i_adv(cmp_now),
		.i_ext_en(1'b1),
		.i_ext_bit(rx_bit),
		.o_bit(ref_bit)
	);

	// ------------------------------------------------------------
	// error tally
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			error_tally_register_r <= 16'h0000;
		end else if (error_count_clear_bit) begin
			error_tally_register_r <= 16'h0000;
		end else if (bit_err && error_tally_register_r != prbst_pkg::ERR_MAX) begin
			error_tally_register_r <= 16'(error_tally_register_r + 16'h0001);
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	always_comb begin
		irq_evt = '0;
		irq_evt[prbst_pkg::IRQ_ERR] = bit_err;
		irq_evt[prbst_pkg::IRQ_SAT] = bit_err && !error_count_clear_bit
			&& (error_tally_register_r == 16'(prbst_pkg::ERR_MAX - 16'h0001));
		irq_evt[prbst_pkg::IRQ_WIN] = cmp_now && (rx_state_r == prbst_pkg::RX_CMP) && (rem_r == 9'h001);
		irq_clr = (i_wr && i_addr == prbst_pkg::ADDR_IRQ_CLR) ? i_wdata[prbst_pkg::IRQ_W-1:0] : '0;
	end

	// sticky status, a new event wins over a clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
		end
	end

	assign o_irq = |(irq_stat_r & irq_en_r);
endmodule : prbst_engine
`default_nettype wire

// ### common/prbst_pkg.sv
// constants and types shared by the pattern test engine
`default_nettype none
package prbst_pkg;
	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 16;
	localparam logic [2:0] CM_REGION = 3'h0; // addr[11:9] of connection memory window
	localparam logic [11:0] ADDR_CTRL = 12'h400;
	localparam logic [11:0] ADDR_RX_START = 12'h401;
	localparam logic [11:0] ADDR_LENGTH = 12'h402;
	localparam logic [11:0] ADDR_ERR_TALLY = 12'h403;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h404;
	localparam logic [11:0] ADDR_IRQ_CLR = 12'h405;
	localparam logic [11:0] ADDR_IRQ_EN = 12'h406;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_CLR_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int unsigned CH_W = 5;
	localparam int unsigned ST_W = 4;
	localparam int unsigned RXS_CH_LSB = 0;
	localparam int unsigned RXS_ST_LSB = 8;
	localparam logic [15:0] RXS_MASK = 16'h0f1f;
	localparam logic [15:0] RXS_RST = 16'h0000;
	localparam int unsigned LEN_W = 6;
	localparam logic [5:0] LEN_MAX = 6'h20;
	localparam logic [5:0] LEN_RST = 6'h01;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_ERR = 0;
	localparam int unsigned IRQ_SAT = 1;
	localparam int unsigned IRQ_WIN = 2;
	// ------------------------------------------------------------
	// connection memory entries
	// ------------------------------------------------------------
	localparam int unsigned CM_W = 12;
	localparam int unsigned CM_DEPTH = 512;
	localparam logic [2:0] CM_MODE_HIZ = 3'h1;
	localparam logic [2:0] CM_MODE_MSG = 3'h3;
	localparam logic [2:0] CM_MODE_TEST = 3'h5;
	localparam logic [3:0] CM_MSG_MSB = 4'ha;
	localparam logic [11:0] CM_RST = 12'h000;
	// ------------------------------------------------------------
	// pattern and counter
	// ------------------------------------------------------------
	localparam int unsigned PRBS_W = 15;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;
	localparam logic [15:0] ERR_MAX = 16'hffff;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_WAIT = 3'h2,
		RX_CMP = 3'h4
	} prbst_rx_state_e;
endpackage : prbst_pkg
`default_nettype wire

// ### logic/prbst_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module prbst_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= '1;
			o_sync <= '1;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule : prbst_sync
`default_nettype wire

// ### logic/prbst_lfsr.sv
// 15-bit pattern shift register, free running or fed from a received stream
`timescale 1ns/1ps
`default_nettype none
module prbst_lfsr (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_adv,
	input wire logic i_ext_en,
	input wire logic i_ext_bit,
	output logic o_bit
);
	logic [prbst_pkg::PRBS_W-1:0] state_r;

	// feedback taps x^15 + x^14 + 1; o_bit is the next pattern bit
	assign o_bit = state_r[14] ^ state_r[13];

	// load seed, or shift in own feedback / the received bit
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= prbst_pkg::PRBS_SEED;
		end else if (i_load) begin
			state_r <= prbst_pkg::PRBS_SEED;
		end else if (i_adv) begin
			state_r <= {state_r[13:0], (i_ext_en ? i_ext_bit : o_bit)};
		end
	end
endmodule : prbst_lfsr
`default_nettype wire

// ### tb/prbst_engine_asserts.sv
// port checker for the pattern test engine
`timescale 1ns/1ps
`default_nettype none
module prbst_engine_asserts #(
	parameter int unsigned N_ST = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [11:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic i_link_clk,
	input wire logic i_frame_n,
	input wire logic [N_ST-1:0] i_serial_input_stream,
	input wire logic [N_ST-1:0] o_serial_output_stream,
	input wire logic [N_ST-1:0] o_serial_output_stream_oe,
	input wire logic o_irq
);
	// ------------------------------------------------------------
	// register bus and interrupt relations
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// clear written, tally read two cycles later once the held clear has zeroed it
	sequence s_clr_wr;
		i_wr && i_addr == prbst_pkg::ADDR_CTRL && i_wdata[prbst_pkg::CTRL_CLR_BIT];
	endsequence
	sequence s_tally_rd;
		i_rd && i_addr == prbst_pkg::ADDR_ERR_TALLY;
	endsequence
	sequence s_en_zero;
		i_rd && i_addr == prbst_pkg::ADDR_IRQ_EN ##1 o_rdata == 16'h0000;
	endsequence
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (i_rd && i_addr[11:9] != prbst_pkg::CM_REGION && (i_addr < prbst_pkg::ADDR_CTRL
		|| i_addr > prbst_pkg::ADDR_IRQ_EN || i_addr == prbst_pkg::ADDR_IRQ_CLR) |=> o_rdata == 16'h0000)
		else $error("unmapped or write-only read not zero");
	a_cm_upper_zero: assert property (i_rd && i_addr[11:9] == prbst_pkg::CM_REGION |=> o_rdata[15:12] == 4'h0)
		else $error("connection entry upper bits not zero");
	a_start_mask: assert property (i_rd && i_addr == prbst_pkg::ADDR_RX_START |=> (o_rdata & ~prbst_pkg::RXS_MASK) == 16'h0000)
		else $error("start register reserved bits set");
	a_len_field: assert property (i_rd && i_addr == prbst_pkg::ADDR_LENGTH |=> o_rdata[15:6] == 10'h000)
		else $error("length register upper bits set");
	a_stat_field: assert property (i_rd && i_addr == prbst_pkg::ADDR_IRQ_STAT |=> o_rdata[15:3] == 13'h0000)
		else $error("status upper bits set");
	a_clear_tally: assert property (s_clr_wr ##2 s_tally_rd |=> o_rdata == 16'h0000)
		else $error("tally not zero right after clear");
	a_irq_masked: assert property (s_en_zero |-> !o_irq)
		else $error("interrupt high with enable zero");
endmodule : prbst_engine_asserts
bind prbst_engine prbst_engine_asserts #(.N_ST(N_ST)) i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_clk(i_link_clk), .i_frame_n(i_frame_n),
	.i_serial_input_stream(i_serial_input_stream), .o_serial_output_stream(o_serial_output_stream),
	.o_serial_output_stream_oe(o_serial_output_stream_oe), .o_irq(o_irq));
`default_nettype wire

// ### tb/prbst_net_model.sv
// network loop model: bit clock, frame pulse and a one-channel loop delay
`timescale 1ns/1ps
`default_nettype none
module prbst_net_model (
	input wire logic i_flip,
	input wire logic [15:0] i_out,
	input wire logic [15:0] i_oe,
	output logic o_link_clk,
	output logic o_frame_n,
	output logic [15:0] o_in,
	output logic [15:0] o_cap,
	output logic [7:0] o_cap_slot
);
	// ------------------------------------------------------------
	// timing and loop
	// ------------------------------------------------------------
	logic [7:0] cnt;
	logic armed;
	logic [15:0] dl [0:7];
	logic [15:0] line;
	// free running bit clock, 80 ns period
	initial begin
		o_link_clk = 1'b0;
		o_frame_n = 1'b1;
		cnt = 8'hff;
		armed = 1'b0;
		o_cap = 16'hffff;
		o_cap_slot = 8'h00;
		for (int i = 0; i < 8; i++) dl[i] = 16'hffff;
		forever #40 o_link_clk = ~o_link_clk;
	end
	// slot count, frame pulse low around the rise of slot 0
	always @(negedge o_link_clk) begin
		cnt <= cnt + 8'h01;
		o_frame_n <= (cnt != 8'hff);
	end
	// released streams show the inverse of the last bit, never a stale copy
	assign line = (i_out & i_oe) | (~o_cap & ~i_oe);
	// capture the settled bit of the previous slot, one flip per arming
	always @(posedge o_link_clk) begin
		o_cap <= line;
		o_cap_slot <= cnt - 8'h01;
		dl[0] <= line ^ {16{armed && cnt == 8'h34}};
		for (int i = 1; i < 8; i++) dl[i] <= dl[i - 1];
		if (armed && cnt == 8'h34) armed <= 1'b0;
	end
	always @(posedge i_flip) armed <= 1'b1;
	assign o_in = dl[7]; // eight bit loop delay
endmodule : prbst_net_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the pattern test engine
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ------------------------------------------------------------
	// signals, instances and shared tasks
	// ------------------------------------------------------------
	localparam logic [11:0] A_CTL = prbst_pkg::ADDR_CTRL;
	localparam logic [11:0] A_TAL = prbst_pkg::ADDR_ERR_TALLY;
	localparam logic [11:0] A_RXS = prbst_pkg::ADDR_RX_START;
	logic i_sys_clk, i_rst_n, i_wr, i_rd, flip, link_clk, frame_n, o_irq;
	logic [11:0] i_addr;
	logic [15:0] i_wdata, o_rdata, sin, sout, soe, cap;
	logic [7:0] cap_slot;
	int err_count, cmp_count;
	logic q [$];
	prbst_engine #(.N_ST(16)) i_prbst_engine (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_clk(link_clk), .i_frame_n(frame_n),
		.i_serial_input_stream(sin), .o_serial_output_stream(sout), .o_serial_output_stream_oe(soe), .o_irq(o_irq));
	prbst_net_model i_prbst_net_model (.i_flip(flip), .i_out(sout), .i_oe(soe), .o_link_clk(link_clk),
		.o_frame_n(frame_n), .o_in(sin), .o_cap(cap), .o_cap_slot(cap_slot));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// bus cycles start right after a rising edge
	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [15:0] v);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_sys_clk);
	endtask : rd
	task automatic rchk(input logic [11:0] a, input logic [15:0] e, input string m);
		logic [15:0] v;
		rd(a, v);
		chk(v, e, m);
	endtask : rchk
	task automatic frames(input int n);
		repeat (n) @(negedge frame_n);
		@(posedge i_sys_clk);
	endtask : frames
	task automatic clr(input logic run);
		wr(A_CTL, {14'h0000, 1'b1, run});
		wr(A_CTL, {15'h0000, run});
	endtask : clr
	// collect stream 2 test slots, count ones violations in its other slots and in every slot of stream 5
	task automatic obs(input int n, output int bad);
		bad = 0;
		q.delete();
		@(negedge frame_n);
		repeat (n * 256) begin
			@(posedge link_clk);
			#1;
			if (cap_slot >= 8'h20 && cap_slot <= 8'h5f) q.push_back(cap[2]);
			else if (cap[2] !== 1'b1) bad++;
			if (cap[5] !== 1'b1) bad++;
		end
		@(posedge i_sys_clk);
	endtask : obs
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [11:0] a [9] = '{A_CTL, A_RXS, prbst_pkg::ADDR_LENGTH, A_TAL, prbst_pkg::ADDR_IRQ_STAT,
			prbst_pkg::ADDR_IRQ_CLR, prbst_pkg::ADDR_IRQ_EN, 12'h7ff, 12'h1ff};
		logic [15:0] e [9] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 9; i++) rchk(a[i], e[i], "reset value");
		wr(A_RXS, 16'hffff);
		rchk(A_RXS, prbst_pkg::RXS_MASK, "start mask");
		wr(A_RXS, 16'h0000);
		wr(12'h1ff, 16'hffff);
		rchk(12'h1ff, 16'h0fff, "entry width");
		wr(12'h1ff, 16'h0000);
		wr(A_TAL, 16'h1234);
		rchk(A_TAL, 16'h0000, "tally read only");
		wr(12'h7ff, 16'hffff);
		rchk(12'h7ff, 16'h0000, "unmapped read");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_tx;
		int bad;
		logic z;
		for (int c = 4; c < 12; c++) wr(12'h040 + 12'(c), {13'h0000, prbst_pkg::CM_MODE_TEST});
		wr(12'h0a4, {13'h0000, prbst_pkg::CM_MODE_TEST});
		obs(1, bad);
		foreach (q[i]) if (q[i] !== 1'b1) bad++;
		chk(16'(bad), 16'h0000, "stopped output not ones");
		wr(A_CTL, 16'h0001);
		frames(1);
		obs(2, bad);
		chk(16'(bad), 16'h0000, "pattern outside its stream or slots");
		z = 1'b0;
		for (int i = 15; i < q.size(); i++) begin
			if (q[i] !== (q[i - 14] ^ q[i - 15])) bad++;
			z = z | ~q[i];
		end
		chk(16'(bad), 16'h0000, "pattern recurrence");
		chk({15'h0000, z}, 16'h0001, "pattern stuck at ones");
		$display("t_tx done");
	endtask : t_tx
	task automatic t_rx;
		logic [15:0] v;
		wr(A_RXS, 16'h0205);
		wr(prbst_pkg::ADDR_LENGTH, 16'h0008);
		frames(3);
		i_wr <= 1'b1;
		i_addr <= A_CTL;
		i_wdata <= 16'h0003;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		// the held clear bit zeroes the tally one edge after the write lands
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= A_TAL;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, 16'h0000, "tally after clear");
		@(posedge i_sys_clk);
		wr(A_CTL, 16'h0001);
		frames(2);
		rchk(A_TAL, 16'h0000, "clean loop counted");
		flip <= 1'b1;
		@(posedge i_sys_clk);
		flip <= 1'b0;
		frames(2);
		rchk(A_TAL, 16'h0003, "one flipped bit");
		wr(A_RXS, 16'h0305);
		clr(1'b1);
		frames(2);
		rd(A_TAL, v);
		chk({15'h0000, v >= 16'h0020}, 16'h0001, "foreign stream not flagged");
		clr(1'b0);
		frames(2);
		rchk(A_TAL, 16'h0000, "stopped receiver counted");
		wr(prbst_pkg::ADDR_LENGTH, 16'h0000);
		clr(1'b1);
		frames(2);
		rchk(A_TAL, 16'h0000, "zero length counted");
		$display("t_rx done");
	endtask : t_rx
	task automatic t_irq;
		rchk(prbst_pkg::ADDR_IRQ_STAT, 16'h0005, "sticky status");
		wr(prbst_pkg::ADDR_IRQ_EN, 16'h0004);
		chk({15'h0000, o_irq}, 16'h0001, "interrupt not raised");
		wr(prbst_pkg::ADDR_IRQ_EN, 16'h0000);
		chk({15'h0000, o_irq}, 16'h0000, "interrupt not masked");
		rchk(prbst_pkg::ADDR_IRQ_EN, 16'h0000, "enable readback");
		wr(A_CTL, 16'h0000);
		wr(prbst_pkg::ADDR_IRQ_CLR, 16'h0007);
		rchk(prbst_pkg::ADDR_IRQ_STAT, 16'h0000, "status not cleared");
		wr(prbst_pkg::ADDR_IRQ_EN, 16'h0007);
		chk({15'h0000, o_irq}, 16'h0000, "interrupt after clear");
		$display("t_irq done");
	endtask : t_irq
	// message bits msb first on stream 7 channel 2, drive released on channel 3
	task automatic t_modes;
		int bad;
		logic [7:0] msg;
		msg = 8'ha5;
		bad = 0;
		wr(12'h0e2, {4'h0, 1'b0, msg, prbst_pkg::CM_MODE_MSG});
		wr(12'h0e3, {13'h0000, prbst_pkg::CM_MODE_HIZ});
		@(negedge frame_n);
		repeat (256) begin
			@(posedge link_clk);
			#1;
			if (cap_slot[7:3] == 5'h02 && cap[7] !== msg[3'h7 - cap_slot[2:0]]) bad++;
			if (soe[7] !== (cap_slot[7:3] != 5'h03)) bad++;
		end
		@(posedge i_sys_clk);
		chk(16'(bad), 16'h0000, "message or released slot wrong");
		$display("t_modes done");
	endtask : t_modes
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// 100 MHz system clock
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// watchdog well beyond the expected run of about 400 us
	initial begin
		#1000000;
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict();
	end
	// main sequence
	initial begin
		{i_rst_n, i_wr, i_rd, flip, i_addr, i_wdata} = '0;
		err_count = 0;
		cmp_count = 0;
		repeat (15) @(posedge i_sys_clk);
		chk(sout, 16'hffff, "outputs in reset");
		chk(soe, 16'h0000, "enables in reset");
		@(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		t_regs();
		t_tx();
		t_rx();
		t_irq();
		t_modes();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
